// File: fbs_pkg.sv
package fbs_pkg;

    localparam int ADDR_W          = 18;
    localparam int DATA_W          = 32;
    localparam int LANE_W          = 8;
    localparam int BURST_W         = 2;
    // wake_settle_time and the sleep entry delay are printed in clock cycles
    localparam int WAKE_SETTLE_CYC = 2;
    localparam int SLEEP_ENTRY_CYC = 2;

    localparam int APB_AW          = 12;
    localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] REG_STAT = 12'h004;
    localparam int CTRL_SLEEP_BIT  = 0;
    localparam logic CTRL_RESET    = 1'h0;

    typedef enum logic [4:0] {
        ST_DESEL = 5'h01,
        ST_READ  = 5'h02,
        ST_WRITE = 5'h04,
        ST_SLEEP = 5'h08,
        ST_WAKE  = 5'h10
    } fbs_state_e;

    // synchronous control pins of the memory bus
    typedef struct packed {
        logic       chip_sel_low_a;
        logic       chip_sel_high;
        logic       chip_sel_low_b;
        logic       advance_or_load;
        logic       read_not_write;
        logic [3:0] byte_write_n;
        logic       clock_hold_n;
        logic       output_drive_en_n;
    } fbs_ctl_s;

    typedef struct packed {
        logic               driving;
        logic               wr_pending;
        logic [BURST_W-1:0] burst_cnt;
        fbs_state_e         state;
    } fbs_stat_s;

endpackage : fbs_pkg

// File: fbs_sram_core.sv
// Notes on behaviour
// - sleep request high: deselected low-power state
// - asleep: inputs ignored, data pins high impedance
// - inputs ignored during sleep, two-cycle wake
// - low order bits linear or interleaved order
// - order pin high or open: interleaved
// - two-bit counter wraps every fourth cycle
// - counter advances on every unheld continue cycle of a read or write burst
// - unselected load deselects; continue keeps deselect
// - selected read load drives data out
// - read with output disabled: dummy read
// - write load, strobed bytes only written
// - all strobes high: write abort, nothing written
// - continue ignores selects, keeps burst type
// - read continue drives per output enable
// - write continue uses that cycle's strobes
// - clock hold freezes state and address
// - hold keeps read driven, write quiet
// - drivers off during writes automatically
// - data pins quiet from power-up
// - inputs sampled on rising edge only
//
// The APB register port and the register offsets were chosen for this implementation.
module fbs_sram_core #(
    parameter int ADDR_W = fbs_pkg::ADDR_W,
    parameter int DATA_W = fbs_pkg::DATA_W
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire fbs_pkg::fbs_ctl_s         ctl_i,
    input  wire logic [ADDR_W-1:0]         addr_i,
    input  wire logic [DATA_W-1:0]         dq_i,
    input  wire logic                      linear_order_sel_n_i,
    input  wire logic                      sleep_request_i,
    output logic      [DATA_W-1:0]         dq_o,
    output logic                           dq_oe_n_o,
    input  wire logic [fbs_pkg::APB_AW-1:0] paddr_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [31:0]               pwdata_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o
);
    localparam int LANES = DATA_W / fbs_pkg::LANE_W;
    localparam int DEPTH = 2 ** ADDR_W;
    localparam int BW    = fbs_pkg::BURST_W;

    fbs_pkg::fbs_state_e state_r;
    fbs_pkg::fbs_state_e state_nxt;
    logic [ADDR_W-1:0]   base_r;
    logic [ADDR_W-1:0]   base_nxt;
    logic [ADDR_W-1:0]   cur_addr_r;
    logic [ADDR_W-1:0]   cur_addr_nxt;
    logic [ADDR_W-1:0]   pw_addr_r;
    logic [ADDR_W-1:0]   pw_addr_nxt;
    logic [ADDR_W-1:0]   rd_addr;
    logic [BW-1:0]       cnt_r;
    logic [BW-1:0]       cnt_nxt;
    logic [BW-1:0]       ncnt;
    logic [BW-1:0]       low_bits;
    logic [1:0]          wake_cnt_r;
    logic [1:0]          wake_cnt_nxt;
    logic                pw_valid_r;
    logic                pw_valid_nxt;
    logic [LANES-1:0]    pw_be_r;
    logic [LANES-1:0]    pw_be_nxt;
    logic [DATA_W-1:0]   dq_r;
    logic [DATA_W-1:0]   dq_nxt;
    logic [DATA_W-1:0]   rd_data;
    logic                oe_n_r;
    logic                oe_n_nxt;
    logic                ctrl_sleep_r;
    logic                ctrl_sleep_nxt;
    logic [31:0]         prdata_r;
    logic [31:0]         prdata_nxt;
    logic                pready_r;
    logic                pready_nxt;
    logic                pslverr_r;
    logic                pslverr_nxt;
    logic                sleep_in;
    logic                en;
    logic                sel;
    logic                active;
    logic                load;
    logic                mem_we;
    logic                apb_setup;
    logic                apb_acc;
    fbs_pkg::fbs_stat_s  stat;

    always_comb
    begin
        sleep_in = sleep_request_i | ctrl_sleep_r;
        en       = ~ctl_i.clock_hold_n;
        load     = ~ctl_i.advance_or_load;
        sel      = ~ctl_i.chip_sel_low_a & ctl_i.chip_sel_high & ~ctl_i.chip_sel_low_b;
        active   = (state_r == fbs_pkg::ST_DESEL) || (state_r == fbs_pkg::ST_READ)
                   || (state_r == fbs_pkg::ST_WRITE);
        ncnt     = BW'(cnt_r + 1'b1);
        // open order pin reads high through the pad pull-up, so interleave is default
        if (!linear_order_sel_n_i)
            low_bits = BW'(base_r[BW-1:0] + ncnt);
        else
            low_bits = base_r[BW-1:0] ^ ncnt;
        rd_addr  = load ? addr_i : {base_r[ADDR_W-1:BW], low_bits};
        // the late write lands on the edge after its command, only on a live edge
        mem_we   = active & en & ~sleep_in & pw_valid_r;
    end

    // a read of the word being written this edge sees the new bytes
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
        // each lane owns its storage, so exactly one process writes it
        logic [fbs_pkg::LANE_W-1:0] mem_r [DEPTH];
        always_comb
        begin
            if (mem_we && pw_be_r[g] && (pw_addr_r == rd_addr))
                rd_data[g*fbs_pkg::LANE_W +: fbs_pkg::LANE_W] =
                    dq_i[g*fbs_pkg::LANE_W +: fbs_pkg::LANE_W];
            else
                rd_data[g*fbs_pkg::LANE_W +: fbs_pkg::LANE_W] = mem_r[rd_addr];
        end

        always_ff @(posedge clk_i)
        begin
            if (mem_we && pw_be_r[g])
                mem_r[pw_addr_r] <= dq_i[g*fbs_pkg::LANE_W +: fbs_pkg::LANE_W];
        end
    end

    always_comb
    begin
        state_nxt    = state_r;
        base_nxt     = base_r;
        cur_addr_nxt = cur_addr_r;
        cnt_nxt      = cnt_r;
        wake_cnt_nxt = wake_cnt_r;
        pw_valid_nxt = pw_valid_r;
        pw_addr_nxt  = pw_addr_r;
        pw_be_nxt    = pw_be_r;
        dq_nxt       = dq_r;
        oe_n_nxt     = oe_n_r;
        case (state_r)
            fbs_pkg::ST_SLEEP:
            begin
                oe_n_nxt = 1'b1;
                if (!sleep_in)
                begin
                    state_nxt    = fbs_pkg::ST_WAKE;
                    wake_cnt_nxt = 2'h0;
                end
            end
            fbs_pkg::ST_WAKE:
            begin
                oe_n_nxt = 1'b1;
                if (sleep_in)
                    state_nxt = fbs_pkg::ST_SLEEP;
                else if (wake_cnt_r == 2'(fbs_pkg::WAKE_SETTLE_CYC - 1))
                    state_nxt = fbs_pkg::ST_DESEL;
                else
                    wake_cnt_nxt = 2'(wake_cnt_r + 1'b1);
            end
            fbs_pkg::ST_DESEL, fbs_pkg::ST_READ, fbs_pkg::ST_WRITE:
            begin
                if (sleep_in)
                begin
                    // a write still waiting for its data is dropped, not finished
                    state_nxt    = fbs_pkg::ST_SLEEP;
                    oe_n_nxt     = 1'b1;
                    pw_valid_nxt = 1'b0;
                end
                else if (en)
                begin
                    pw_valid_nxt = 1'b0;
                    if (load && !sel)
                    begin
                        state_nxt = fbs_pkg::ST_DESEL;
                        oe_n_nxt  = 1'b1;
                    end
                    else if (load)
                    begin
                        base_nxt     = addr_i;
                        cur_addr_nxt = addr_i;
                        cnt_nxt      = '0;
                        if (ctl_i.read_not_write)
                        begin
                            state_nxt = fbs_pkg::ST_READ;
                            dq_nxt    = rd_data;
                            oe_n_nxt  = ctl_i.output_drive_en_n;
                        end
                        else
                        begin
                            state_nxt    = fbs_pkg::ST_WRITE;
                            oe_n_nxt     = 1'b1;
                            pw_valid_nxt = ~&ctl_i.byte_write_n;
                            pw_addr_nxt  = addr_i;
                            pw_be_nxt    = ~ctl_i.byte_write_n;
                        end
                    end
                    else if (state_r == fbs_pkg::ST_READ)
                    begin
                        cnt_nxt      = ncnt;
                        cur_addr_nxt = rd_addr;
                        dq_nxt       = rd_data;
                        oe_n_nxt     = ctl_i.output_drive_en_n;
                    end
                    else if (state_r == fbs_pkg::ST_WRITE)
                    begin
                        cnt_nxt      = ncnt;
                        cur_addr_nxt = rd_addr;
                        pw_valid_nxt = ~&ctl_i.byte_write_n;
                        pw_addr_nxt  = rd_addr;
                        pw_be_nxt    = ~ctl_i.byte_write_n;
                    end
                end
            end
            default:
            begin
                state_nxt = fbs_pkg::ST_DESEL;
                oe_n_nxt  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r    <= fbs_pkg::ST_DESEL;
            base_r     <= '0;
            cur_addr_r <= '0;
            cnt_r      <= '0;
            wake_cnt_r <= 2'h0;
            pw_valid_r <= 1'b0;
            pw_addr_r  <= '0;
            pw_be_r    <= '0;
            dq_r       <= '0;
            oe_n_r     <= 1'b1;
        end
        else
        begin
            state_r    <= state_nxt;
            base_r     <= base_nxt;
            cur_addr_r <= cur_addr_nxt;
            cnt_r      <= cnt_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            pw_valid_r <= pw_valid_nxt;
            pw_addr_r  <= pw_addr_nxt;
            pw_be_r    <= pw_be_nxt;
            dq_r       <= dq_nxt;
            oe_n_r     <= oe_n_nxt;
        end
    end

    assign dq_o      = dq_r;
    assign dq_oe_n_o = oe_n_r;

    // zero-wait slave: pready is raised for the first access cycle
    always_comb
    begin
        apb_setup       = psel_i & ~penable_i;
        apb_acc         = psel_i & penable_i & pready_r;
        stat.driving    = ~oe_n_r;
        stat.wr_pending = pw_valid_r;
        stat.burst_cnt  = cnt_r;
        stat.state      = state_r;
        pready_nxt      = apb_setup;
        pslverr_nxt     = 1'b0;
        prdata_nxt      = 32'h0000_0000;
        ctrl_sleep_nxt  = ctrl_sleep_r;
        if (apb_setup)
        begin
            if (paddr_i == fbs_pkg::REG_CTRL)
                prdata_nxt[fbs_pkg::CTRL_SLEEP_BIT] = ctrl_sleep_r;
            else if (paddr_i == fbs_pkg::REG_STAT)
                prdata_nxt = 32'(stat);
            else
                pslverr_nxt = 1'b1;
        end
        if (apb_acc && pwrite_i && (paddr_i == fbs_pkg::REG_CTRL))
            ctrl_sleep_nxt = pwdata_i[fbs_pkg::CTRL_SLEEP_BIT];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_sleep_r <= fbs_pkg::CTRL_RESET;
            prdata_r     <= 32'h0000_0000;
            pready_r     <= 1'b0;
            pslverr_r    <= 1'b0;
        end
        else
        begin
            ctrl_sleep_r <= ctrl_sleep_nxt;
            prdata_r     <= prdata_nxt;
            pready_r     <= pready_nxt;
            pslverr_r    <= pslverr_nxt;
        end
    end

    assign prdata_o  = prdata_r;
    assign pready_o  = pready_r;
    assign pslverr_o = pslverr_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_live;
        active && en && !sleep_in;
    endsequence
    sequence s_wake_start;
        (state_r == fbs_pkg::ST_SLEEP) && !sleep_in ##1 !sleep_in ##1 !sleep_in;
    endsequence

    property p_sleep_enter;
        active && sleep_in |=> (state_r == fbs_pkg::ST_SLEEP) && dq_oe_n_o;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

    property p_sleep_freeze;
        state_r == fbs_pkg::ST_SLEEP |=> $stable(cur_addr_r) && $stable(cnt_r) && dq_oe_n_o;
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("input used in sleep");

    property p_wake_settle;
        s_wake_start |=> state_r == fbs_pkg::ST_DESEL;
    endproperty
    a_wake_settle: assert property (p_wake_settle) else $error("wake settle wrong");

    property p_deselect;
        s_live and (load && !sel) |=> (state_r == fbs_pkg::ST_DESEL) && dq_oe_n_o;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect failed");

    property p_read_drive;
        s_live and (load && sel && ctl_i.read_not_write)
            |=> (dq_oe_n_o == $past(ctl_i.output_drive_en_n)) && (cur_addr_r == $past(addr_i));
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read start wrong");

    property p_write_quiet;
        state_r == fbs_pkg::ST_WRITE |-> dq_oe_n_o;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("driving in write");

    property p_write_abort;
        s_live and (load && sel && !ctl_i.read_not_write && (&ctl_i.byte_write_n))
            |=> !pw_valid_r && !mem_we;
    endproperty
    a_write_abort: assert property (p_write_abort) else $error("abort wrote");

    property p_late_write;
        s_live and (load && sel && !ctl_i.read_not_write && !(&ctl_i.byte_write_n))
            |=> pw_valid_r && (pw_addr_r == $past(addr_i));
    endproperty
    a_late_write: assert property (p_late_write) else $error("write not queued");

    property p_linear;
        s_live and (!load && (state_r == fbs_pkg::ST_READ) && !linear_order_sel_n_i)
            |=> cur_addr_r[BW-1:0] == BW'($past(cur_addr_r[BW-1:0]) + 1'b1);
    endproperty
    a_linear: assert property (p_linear) else $error("linear order wrong");

    property p_wrap;
        s_live and (!load && (state_r != fbs_pkg::ST_DESEL) && (cnt_r == 2'h3))
            |=> cur_addr_r == base_r;
    endproperty
    a_wrap: assert property (p_wrap) else $error("burst did not wrap");

    property p_hold;
        active && !en && !sleep_in
            |=> $stable(cur_addr_r) && $stable(state_r) && $stable(dq_oe_n_o);
    endproperty
    a_hold: assert property (p_hold) else $error("hold not honoured");

    property p_powerup;
        $past(rst_i) |-> dq_oe_n_o;
    endproperty
    a_powerup: assert property (p_powerup) else $error("data driven at power-up");

endmodule : fbs_sram_core

// File: fbs_mem_ctrl.sv
module fbs_mem_ctrl #(
    parameter int AW = 6
) (
    input  wire logic         clk_i,
    output fbs_pkg::fbs_ctl_s ctl_o,
    output logic [AW-1:0]     addr_o,
    output logic [31:0]       dq_o,
    output logic              sleep_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        pend_v;
    logic [31:0] pend_d;
    initial
    begin
        ctl_o = '0;
        ctl_o.chip_sel_low_a = 1'b1;
        addr_o  = '0;
        dq_o    = 32'h0;
        sleep_o = 1'b0;
        pend_v  = 1'b0;
        pend_d  = 32'h0;
    end
    // write data trails its command by one live edge; a held edge keeps it waiting
    // idle data cycles carry the inverse of the last word, never a stale copy
    task automatic drive(input fbs_pkg::fbs_ctl_s c, input logic [AW-1:0] a,
                         input logic [31:0] d, input logic dv);
        @(posedge clk_i);
        ctl_o  <= c;
        addr_o <= a;
        if (c.clock_hold_n)
            dq_o <= ~dq_o;
        else
        begin
            dq_o   <= pend_v ? pend_d : ~dq_o;
            pend_v <= dv;
            pend_d <= d;
        end
    endtask : drive
    // callers raise it while a read burst is still driving, with no write outstanding
    task automatic set_sleep(input logic v);
        @(posedge clk_i);
        sleep_o <= v;
    endtask : set_sleep
endmodule : fbs_mem_ctrl

// File: tb_flowthrough_burst_sram_control.sv
module tb_flowthrough_burst_sram_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AW = 6;
    logic              clk_i;
    logic              rst_i;
    logic              lin_n;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic              pready;
    logic              pslverr;
    logic              oe_n;
    logic              sleep;
    logic [11:0]       paddr;
    logic [AW-1:0]     addr;
    logic [31:0]       dq_in;
    logic [31:0]       dq_out;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic [31:0]       em [64];
    fbs_pkg::fbs_ctl_s ctl;
    int                miscompares = 0;
    int                compares = 0;

    fbs_mem_ctrl #(.AW(AW)) m (.clk_i(clk_i), .ctl_o(ctl), .addr_o(addr), .dq_o(dq_in),
        .sleep_o(sleep));
    fbs_sram_core #(.ADDR_W(AW), .DATA_W(32)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ctl_i(ctl), .addr_i(addr), .dq_i(dq_in),
        .linear_order_sel_n_i(lin_n), .sleep_request_i(sleep), .dq_o(dq_out),
        .dq_oe_n_o(oe_n), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // the whole run is about 110 cycles; the 10000-cycle limit leaves ample margin
    initial
    begin
        #100000;
        miscompares++;
        conclude();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask : chk

    function automatic logic [AW-1:0] ord(input logic [AW-1:0] b, input int i);
        return lin_n ? {b[AW-1:2], b[1:0] ^ 2'(i)} : {b[AW-1:2], b[1:0] + 2'(i)};
    endfunction : ord

    task automatic upd(input logic [AW-1:0] a, input logic [3:0] b, input logic [31:0] d);
        for (int g = 0; g < 4; g++)
            if (!b[g])
                em[a][8*g+:8] = d[8*g+:8];
    endtask : upd

    task automatic op(input logic s, v, r, input logic [3:0] b, input logic h, o,
                      input logic [AW-1:0] a, input logic [31:0] d, input logic dv);
        m.drive('{!s, s, !s, v, r, b, h, o}, a, d, dv);
    endtask : op

    task automatic rdl(input logic [AW-1:0] a, input logic o);
        op(1'b1, 1'b0, 1'b1, 4'hF, 1'b0, o, a, 32'h0, 1'b0);
    endtask : rdl

    // continue cycles carry hostile selects and direction, which must be ignored
    task automatic rc(input logic o);
        op(1'b0, 1'b1, 1'b0, 4'h0, 1'b0, o, '0, 32'h0, 1'b0);
    endtask : rc

    task automatic ds();
        op(1'b0, 1'b0, 1'b1, 4'hF, 1'b0, 1'b0, '0, 32'h0, 1'b0);
    endtask : ds

    task automatic hd();
        op(1'b0, 1'b1, 1'b0, 4'h0, 1'b1, 1'b0, '0, 32'h0, 1'b0);
    endtask : hd

    task automatic wl(input logic [AW-1:0] a, input logic [3:0] b, input logic [31:0] d);
        op(1'b1, 1'b0, 1'b0, b, 1'b0, 1'b0, a, d, 1'b1);
    endtask : wl

    task automatic setlin(input logic v);
        @(posedge clk_i);
        lin_n <= v;
    endtask : setlin

    task automatic wburst(input logic [AW-1:0] base, input logic [3:0] b0, bc,
                          input logic [7:0] k);
        logic [31:0] d;
        for (int i = 0; i < 4; i++)
        begin
            d = {k, 8'(base), 8'(i), ~k};
            if (i == 0)
                wl(base, b0, d);
            else
                op(1'b0, 1'b1, 1'b1, bc, 1'b0, 1'b0, '0, d, 1'b1);
            upd(ord(base, i), i == 0 ? b0 : bc, d);
            #2;
            if (i > 0)
                chk(32'(oe_n), 32'h1, "write drive off");
        end
        ds();
    endtask : wburst

    task automatic rburst(input logic [AW-1:0] base);
        rdl(base, 1'b0);
        for (int i = 0; i < 5; i++)
        begin
            rc(1'b0);
            #2;
            chk(dq_out, em[ord(base, i)], "read data");
            chk(32'(oe_n), 32'h0, "read drive");
        end
        ds();
    endtask : rburst

    task automatic t_burst();
        setlin(1'b1);
        wburst(6'h01, 4'h0, 4'h0, 8'h11);
        setlin(1'b0);
        rburst(6'h01);
        wburst(6'h0F, 4'h0, 4'h0, 8'h22);
        setlin(1'b1);
        rburst(6'h0F);
        wburst(6'h08, 4'h0, 4'h0, 8'h33);
        wburst(6'h08, 4'hA, 4'hF, 8'h44);
        wburst(6'h09, 4'hF, 4'h6, 8'h55);
        rburst(6'h08);
        $display("burst and strobe test done");
    endtask : t_burst

    task automatic t_ctl();
        rdl(6'h01, 1'b1);
        rc(1'b1);
        #2;
        chk(32'(oe_n), 32'h1, "dummy read");
        rc(1'b0);
        #2;
        chk(32'(oe_n), 32'h1, "dummy continue");
        ds();
        #2;
        chk(dq_out, em[ord(6'h01, 2)], "continue data");
        chk(32'(oe_n), 32'h0, "continue drive");
        rc(1'b0);
        #2;
        chk(32'(oe_n), 32'h1, "deselect");
        ds();
        #2;
        chk(32'(oe_n), 32'h1, "continue deselect");
        $display("dummy and deselect test done");
    endtask : t_ctl

    task automatic t_hold();
        rdl(6'h0F, 1'b0);
        hd();
        hd();
        #2;
        chk(dq_out, em[6'h0F], "hold keeps data");
        chk(32'(oe_n), 32'h0, "hold keeps drive");
        rc(1'b0);
        ds();
        #2;
        chk(dq_out, em[ord(6'h0F, 1)], "address held");
        wl(6'h20, 4'h0, 32'hC0DE0001);
        upd(6'h20, 4'h0, 32'hC0DE0001);
        hd();
        ds();
        #2;
        chk(32'(oe_n), 32'h1, "hold in write");
        rdl(6'h20, 1'b0);
        ds();
        #2;
        chk(dq_out, em[6'h20], "write after hold");
        wl(6'h21, 4'h0, 32'h5A5A0F0F);
        upd(6'h21, 4'h0, 32'h5A5A0F0F);
        rdl(6'h21, 1'b0);
        ds();
        #2;
        chk(dq_out, em[6'h21], "read right after write");
        $display("hold test done");
    endtask : t_hold

    task automatic t_sleep();
        rdl(6'h08, 1'b0);
        m.set_sleep(1'b1);
        wl(6'h08, 4'h0, 32'hBAD00001);
        #2;
        chk(32'(oe_n), 32'h1, "asleep quiet");
        rdl(6'h08, 1'b0);
        #2;
        chk(32'(oe_n), 32'h1, "asleep ignores read");
        m.set_sleep(1'b0);
        ds();
        ds();
        rdl(6'h08, 1'b0);
        ds();
        #2;
        chk(dq_out, em[6'h08], "write ignored in sleep");
        chk(32'(oe_n), 32'h0, "awake drive");
        $display("sleep test done");
    endtask : t_sleep

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk(32'(pready), 32'h1, "apb ready");
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic t_apb();
        logic [31:0] r;
        logic        e;
        apb(1'b0, fbs_pkg::REG_CTRL, 32'h0, r, e);
        chk(r, 32'(fbs_pkg::CTRL_RESET), "ctrl reset");
        apb(1'b1, fbs_pkg::REG_CTRL, 32'h1, r, e);
        apb(1'b0, fbs_pkg::REG_STAT, 32'h0, r, e);
        chk(r & 32'h1F, 32'h8, "soft sleep state");
        chk(32'(oe_n), 32'h1, "soft sleep quiet");
        apb(1'b1, fbs_pkg::REG_CTRL, 32'h0, r, e);
        apb(1'b0, 12'h008, 32'h0, r, e);
        chk(r, 32'h0, "unmapped data");
        chk(32'(e), 32'h1, "unmapped error");
        $display("register test done");
    endtask : t_apb

    initial
    begin
        rst_i   = 1'b1;
        lin_n   = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        repeat (20) @(posedge clk_i);
        chk(32'(oe_n), 32'h1, "reset quiet");
        rst_i <= 1'b0;
        t_burst();
        t_ctl();
        t_hold();
        t_sleep();
        t_apb();
        conclude();
    end
endmodule : tb_flowthrough_burst_sram_control
